//--- dcsw_top.sv
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/10ps
`include "dcsw_params.svh"
// Summary of operation
// - One command source selected at a time; terminal block after reset.
// - CANopen and fieldbus sources selectable only with their module present.
// - Outside I/O profile, command bit 0 high requests switch-on.
// - State machine profile: bit 1 low disables voltage.
// - State machine profile: bit 2 low requests quick stop.
// - State machine profile: bit 3 high enables operation.
// - State machine profile: fault reset only on rising edge of bit 7.
// - State machine profile: bit 8 high halts, staying operation enabled.
// - Bits 4-6, 9, 10 kept zero by master; bits 11-15 user commands.
// - I/O 2-wire: bit 0 high is forward run; bits 1-15 assignable.
// - I/O fixed bits act only while their source is active.
// - I/O 3-wire: bit 0 authorizes run, bit 1 rising edge starts forward.
// - Read-only signed pre-ramp reference, resets to 0 Hz.
// - State bits 0-2: ready to switch on, switched on, operation enabled.
// - State bit 3 is fault state.
// - State bit 4 is supply present; forced 1 on power-section-only supply.
// - State bit 5 quick stop, bit 6 switch-on disabled.
// - State bit 7 warning; bit 8 reads zero.
// - State bit 9: network command versus terminal block or display terminal.
// - State bit 10 reference reached, bit 11 reference outside limits.
// - State bit 14 stop key, bit 15 reverse direction.
// - Drive state encoded jointly by state bits 0,1,2,3,5,6.
module dcsw_top (
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 canopen_present,
    input  wire logic                 fieldbus_present,
    input  wire logic                 power_section_only,
    input  wire logic [15:0]          terminal_cmd,
    input  wire logic [15:0]          display_terminal_cmd,
    input  wire logic [15:0]          modbus_cmd,
    input  wire logic [15:0]          canopen_cmd,
    input  wire logic [15:0]          fieldbus_cmd,
    input  wire logic [15:0]          ethernet_cmd,
    input  wire logic signed [15:0]   ref_applied,
    input  wire dcsw_pkg::dcsw_status_s drive_status,
    output dcsw_pkg::dcsw_cmd_s       drive_cmd,
    output logic [15:0]               drive_state_word,
    output logic signed [15:0]        pre_ramp_ref
);
    import dcsw_pkg::*;

    dcsw_src_e   cmd_source;
    dcsw_prof_e  profile;
    logic [15:0] command_word;
    logic [15:0] active_cmd;
    logic [15:0] prev_cmd;
    dcsw_src_e   prev_src;
    logic        fault_reset_seen;
    logic        fwd_start_seen;
    logic        source_changed;
    dcsw_cmd_s   next_drive_cmd;
    logic [15:0] next_state_word;

    wire wr_en = psel && penable && pwrite;
    wire rd_en = psel && penable && !pwrite;

    function automatic logic src_legal(input logic [2:0] s, input logic can_p,
                                       input logic fb_p);
        case (s)
            3'h0, 3'h1, 3'h2, 3'h5: src_legal = 1'b1;
            3'h3:                   src_legal = can_p;
            3'h4:                   src_legal = fb_p;
            default:                src_legal = 1'b0;
        endcase
    endfunction : src_legal

    function automatic logic is_net(input dcsw_src_e s);
        is_net = (s == DCSW_SRC_MODBUS) || (s == DCSW_SRC_CANOPEN) ||
                 (s == DCSW_SRC_FIELDBUS) || (s == DCSW_SRC_ONBOARD_ETHERNET);
    endfunction : is_net

    function automatic logic decode_hit(input logic [11:0] a, input logic [11:0] o);
        decode_hit = (a == o);
    endfunction : decode_hit

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cmd_source <= dcsw_src_e'(`DCSW_SRC_RESET);
        end else if (wr_en && decode_hit(paddr, `DCSW_OFS_CMD_SOURCE) &&
                     src_legal(pwdata[2:0], canopen_present, fieldbus_present)) begin
            cmd_source <= dcsw_src_e'(pwdata[2:0]);
        end else if ((cmd_source == DCSW_SRC_CANOPEN && !canopen_present) ||
                     (cmd_source == DCSW_SRC_FIELDBUS && !fieldbus_present)) begin
            cmd_source <= dcsw_src_e'(`DCSW_SRC_RESET);
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            profile <= dcsw_prof_e'(`DCSW_PROFILE_RESET);
        end else if (wr_en && decode_hit(paddr, `DCSW_OFS_PROFILE) && pwdata[1:0] != 2'h3) begin
            profile <= dcsw_prof_e'(pwdata[1:0]);
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            command_word <= `DCSW_CMD_RESET;
        end else if (wr_en && decode_hit(paddr, `DCSW_OFS_CMD_WORD)) begin
            command_word <= pwdata[15:0];
        end
    end

    always_comb begin
        unique case (cmd_source)
            DCSW_SRC_TERMINAL:         active_cmd = terminal_cmd;
            DCSW_SRC_DISPLAY_TERMINAL: active_cmd = display_terminal_cmd;
            DCSW_SRC_MODBUS:           active_cmd = modbus_cmd | command_word;
            DCSW_SRC_CANOPEN:          active_cmd = canopen_cmd;
            DCSW_SRC_FIELDBUS:         active_cmd = fieldbus_cmd;
            DCSW_SRC_ONBOARD_ETHERNET: active_cmd = ethernet_cmd;
            default:                   active_cmd = 16'h0000;
        endcase
    end

    // Edge history restarts on a source change so a switch cannot fake an edge
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prev_cmd <= 16'h0000;
            prev_src <= DCSW_SRC_TERMINAL;
        end else begin
            prev_cmd <= active_cmd;
            prev_src <= cmd_source;
        end
    end

    assign source_changed = (cmd_source != prev_src);

    assign fault_reset_seen = active_cmd[`DCSW_CB_FAULT_RESET] &&
                              !prev_cmd[`DCSW_CB_FAULT_RESET] && !source_changed;
    assign fwd_start_seen   = active_cmd[`DCSW_CB_IO3_FWD_EDGE] &&
                              !prev_cmd[`DCSW_CB_IO3_FWD_EDGE] && !source_changed;

    always_comb begin
        next_drive_cmd = '0;
        next_drive_cmd.user_cmd = active_cmd[15:11];
        unique case (profile)
            DCSW_PROF_STATE_MACHINE: begin
                next_drive_cmd.switch_on       = active_cmd[`DCSW_CB_SWITCH_ON];
                next_drive_cmd.disable_voltage = !active_cmd[`DCSW_CB_VOLTAGE_N];
                next_drive_cmd.quick_stop      = !active_cmd[`DCSW_CB_QSTOP_N];
                next_drive_cmd.enable_op       = active_cmd[`DCSW_CB_ENABLE_OP];
                next_drive_cmd.fault_reset     = fault_reset_seen;
                next_drive_cmd.halt            = active_cmd[`DCSW_CB_HALT];
            end
            DCSW_PROF_IO_2WIRE: begin
                next_drive_cmd.fwd_run = active_cmd[`DCSW_CB_IO_FWD];
            end
            DCSW_PROF_IO_3WIRE: begin
                next_drive_cmd.run_auth  = active_cmd[`DCSW_CB_IO3_RUN_AUTH];
                next_drive_cmd.fwd_start = fwd_start_seen &&
                                           active_cmd[`DCSW_CB_IO3_RUN_AUTH];
            end
            default: begin
                next_drive_cmd = '0;
            end
        endcase
    end

    always_comb begin
        next_state_word = 16'h0000;
        next_state_word[0]  = drive_status.ready_to_switch_on;
        next_state_word[1]  = drive_status.switched_on;
        next_state_word[2]  = drive_status.operation_enabled;
        next_state_word[3]  = drive_status.fault;
        next_state_word[4]  = drive_status.voltage_present || power_section_only;
        next_state_word[5]  = drive_status.quick_stop;
        next_state_word[6]  = drive_status.switch_on_disabled;
        next_state_word[7]  = drive_status.warning;
        next_state_word[9]  = is_net(cmd_source);
        next_state_word[10] = drive_status.ref_reached;
        next_state_word[11] = drive_status.ref_out_of_limits;
        next_state_word[14] = drive_status.stop_key;
        next_state_word[15] = drive_status.reverse;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            drive_cmd        <= '0;
            drive_state_word <= 16'h0000;
            pre_ramp_ref     <= 16'sh0000;
        end else begin
            drive_cmd        <= next_drive_cmd;
            drive_state_word <= next_state_word;
            pre_ramp_ref     <= ref_applied;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && !penable) begin
                unique case (paddr)
                    `DCSW_OFS_CMD_SOURCE:   prdata <= {29'h0, cmd_source};
                    `DCSW_OFS_PROFILE:      prdata <= {30'h0, profile};
                    `DCSW_OFS_CMD_WORD:     prdata <= {16'h0, command_word};
                    `DCSW_OFS_STATE_WORD:   prdata <= {16'h0, drive_state_word};
                    `DCSW_OFS_PRE_RAMP_REF: prdata <= {{16{pre_ramp_ref[15]}}, pre_ramp_ref};
                    `DCSW_OFS_EVENTS:       prdata <= {16'h0, active_cmd};
                    `DCSW_OFS_OUTPUTS:      prdata <= {18'h0, drive_cmd};
                    default:                pslverr <= 1'b1;
                endcase
            end
        end
    end

    sequence s_edge7;
        !active_cmd[`DCSW_CB_FAULT_RESET] ##1 active_cmd[`DCSW_CB_FAULT_RESET];
    endsequence

    sequence s_edge1;
        !active_cmd[`DCSW_CB_IO3_FWD_EDGE] ##1 active_cmd[`DCSW_CB_IO3_FWD_EDGE];
    endsequence

    a_src_reset_default: assert property (@(posedge core_clk)
        $fell(rst) |-> cmd_source == DCSW_SRC_TERMINAL)
        else $error("source not terminal after reset");
    a_can_needs_module: assert property (@(posedge core_clk) disable iff (rst)
        cmd_source == DCSW_SRC_CANOPEN |-> $past(canopen_present))
        else $error("canopen source without module");
    a_fb_needs_module: assert property (@(posedge core_clk) disable iff (rst)
        cmd_source == DCSW_SRC_FIELDBUS |-> $past(fieldbus_present))
        else $error("fieldbus source without module");
    a_switch_on_map: assert property (@(posedge core_clk) disable iff (rst)
        profile == DCSW_PROF_STATE_MACHINE && $stable(profile) |=>
        drive_cmd.switch_on == $past(active_cmd[0]))
        else $error("switch on not mapped");
    a_voltage_low: assert property (@(posedge core_clk) disable iff (rst)
        !rst && profile == DCSW_PROF_STATE_MACHINE && !active_cmd[1] |=> drive_cmd.disable_voltage)
        else $error("disable voltage missed");
    a_qstop_low: assert property (@(posedge core_clk) disable iff (rst)
        !rst && profile == DCSW_PROF_STATE_MACHINE && !active_cmd[2] |=> drive_cmd.quick_stop)
        else $error("quick stop missed");
    a_fault_edge: assert property (@(posedge core_clk) disable iff (rst)
        s_edge7 ##0 (profile == DCSW_PROF_STATE_MACHINE && $stable(cmd_source))
        |=> drive_cmd.fault_reset)
        else $error("fault reset edge missed");
    a_fault_level: assert property (@(posedge core_clk) disable iff (rst)
        drive_cmd.fault_reset |-> $past(fault_reset_seen))
        else $error("fault reset on level");
    a_io3_start: assert property (@(posedge core_clk) disable iff (rst)
        drive_cmd.fwd_start |-> $past(active_cmd[0]) && $past(profile) == DCSW_PROF_IO_3WIRE)
        else $error("start without run authorization");
    a_supply_bit: assert property (@(posedge core_clk) disable iff (rst)
        power_section_only |=> drive_state_word[4])
        else $error("supply bit not forced");
    a_bit8_zero: assert property (@(posedge core_clk) disable iff (rst)
        drive_state_word[8] == 1'b0 && drive_state_word[13:12] == 2'b00)
        else $error("reserved state bit set");
    a_net_bit: assert property (@(posedge core_clk) disable iff (rst)
        cmd_source == DCSW_SRC_DISPLAY_TERMINAL && $stable(cmd_source) |=> !drive_state_word[9])
        else $error("remote bit wrong");
    a_voltage_high: assert property (@(posedge core_clk) disable iff (rst)
        profile == DCSW_PROF_STATE_MACHINE && active_cmd[1] |=> !drive_cmd.disable_voltage)
        else $error("disable voltage without request");
    a_qstop_high: assert property (@(posedge core_clk) disable iff (rst)
        profile == DCSW_PROF_STATE_MACHINE && active_cmd[2] |=> !drive_cmd.quick_stop)
        else $error("quick stop without request");
    a_enable_map: assert property (@(posedge core_clk) disable iff (rst)
        profile == DCSW_PROF_STATE_MACHINE |=> drive_cmd.enable_op == $past(active_cmd[3]))
        else $error("enable operation not mapped");
    a_halt_map: assert property (@(posedge core_clk) disable iff (rst)
        profile == DCSW_PROF_STATE_MACHINE |=> drive_cmd.halt == $past(active_cmd[8]))
        else $error("halt not mapped");
    a_user_bits: assert property (@(posedge core_clk) disable iff (rst)
        1'b1 |=> drive_cmd.user_cmd == $past(active_cmd[15:11]))
        else $error("user command bits not mapped");
    a_io_no_switch: assert property (@(posedge core_clk) disable iff (rst)
        profile != DCSW_PROF_STATE_MACHINE |=> !drive_cmd.switch_on)
        else $error("switch on outside state machine profile");
    a_fault_io_quiet: assert property (@(posedge core_clk) disable iff (rst)
        profile != DCSW_PROF_STATE_MACHINE |=> !drive_cmd.fault_reset)
        else $error("fault reset outside state machine profile");
    a_fwd_run_map: assert property (@(posedge core_clk) disable iff (rst)
        profile == DCSW_PROF_IO_2WIRE |=> drive_cmd.fwd_run == $past(active_cmd[0]))
        else $error("forward run not mapped");
    a_fwd_run_quiet: assert property (@(posedge core_clk) disable iff (rst)
        profile != DCSW_PROF_IO_2WIRE |=> !drive_cmd.fwd_run)
        else $error("forward run outside two wire mode");
    a_run_auth_map: assert property (@(posedge core_clk) disable iff (rst)
        profile == DCSW_PROF_IO_3WIRE |=> drive_cmd.run_auth == $past(active_cmd[0]))
        else $error("run authorization not mapped");
    a_io3_edge: assert property (@(posedge core_clk) disable iff (rst)
        s_edge1 ##0 (profile == DCSW_PROF_IO_3WIRE && active_cmd[`DCSW_CB_IO3_RUN_AUTH] &&
        $stable(cmd_source)) |=> drive_cmd.fwd_start)
        else $error("forward start edge missed");
    a_io3_quiet: assert property (@(posedge core_clk) disable iff (rst)
        profile != DCSW_PROF_IO_3WIRE |=> !drive_cmd.run_auth && !drive_cmd.fwd_start)
        else $error("three wire command outside three wire mode");
    a_pre_ramp_copy: assert property (@(posedge core_clk) disable iff (rst)
        1'b1 |=> pre_ramp_ref == $past(ref_applied))
        else $error("pre-ramp reference not applied");
    a_state_bits: assert property (@(posedge core_clk) disable iff (rst)
        1'b1 |=> drive_state_word[0] == $past(drive_status.ready_to_switch_on) &&
                 drive_state_word[1] == $past(drive_status.switched_on) &&
                 drive_state_word[2] == $past(drive_status.operation_enabled))
        else $error("drive state bits wrong");
    a_fault_bit: assert property (@(posedge core_clk) disable iff (rst)
        1'b1 |=> drive_state_word[3] == $past(drive_status.fault))
        else $error("fault bit wrong");
    a_supply_follow: assert property (@(posedge core_clk) disable iff (rst)
        !power_section_only |=> drive_state_word[4] == $past(drive_status.voltage_present))
        else $error("supply bit wrong");
    a_qstop_bits: assert property (@(posedge core_clk) disable iff (rst)
        1'b1 |=> drive_state_word[5] == $past(drive_status.quick_stop) &&
                 drive_state_word[6] == $past(drive_status.switch_on_disabled))
        else $error("quick stop or disabled bit wrong");
    a_warn_bit: assert property (@(posedge core_clk) disable iff (rst)
        1'b1 |=> drive_state_word[7] == $past(drive_status.warning))
        else $error("warning bit wrong");
    a_net_remote: assert property (@(posedge core_clk) disable iff (rst)
        cmd_source != DCSW_SRC_TERMINAL && cmd_source != DCSW_SRC_DISPLAY_TERMINAL
        |=> drive_state_word[9])
        else $error("remote bit not set for network source");
    a_ref_bits: assert property (@(posedge core_clk) disable iff (rst)
        1'b1 |=> drive_state_word[10] == $past(drive_status.ref_reached) &&
                 drive_state_word[11] == $past(drive_status.ref_out_of_limits))
        else $error("reference bits wrong");
    a_dir_bits: assert property (@(posedge core_clk) disable iff (rst)
        1'b1 |=> drive_state_word[14] == $past(drive_status.stop_key) &&
                 drive_state_word[15] == $past(drive_status.reverse))
        else $error("stop key or direction bit wrong");
    a_can_fallback: assert property (@(posedge core_clk) disable iff (rst)
        cmd_source == DCSW_SRC_CANOPEN && !canopen_present |=> cmd_source != DCSW_SRC_CANOPEN)
        else $error("canopen source kept without module");
    a_fb_fallback: assert property (@(posedge core_clk) disable iff (rst)
        cmd_source == DCSW_SRC_FIELDBUS && !fieldbus_present |=> cmd_source != DCSW_SRC_FIELDBUS)
        else $error("fieldbus source kept without module");
    a_src_code_legal: assert property (@(posedge core_clk) disable iff (rst)
        cmd_source <= DCSW_SRC_ONBOARD_ETHERNET)
        else $error("command source code out of range");
endmodule : dcsw_top

//--- dcsw_params.svh
`ifndef DCSW_PARAMS_SVH
`define DCSW_PARAMS_SVH
`define DCSW_OFS_CMD_SOURCE   12'h000
`define DCSW_OFS_PROFILE      12'h004
`define DCSW_OFS_CMD_WORD     12'h008
`define DCSW_OFS_STATE_WORD   12'h00C
`define DCSW_OFS_PRE_RAMP_REF 12'h010
`define DCSW_OFS_EVENTS       12'h014
`define DCSW_OFS_OUTPUTS      12'h018
`define DCSW_CB_SWITCH_ON     0
`define DCSW_CB_VOLTAGE_N     1
`define DCSW_CB_QSTOP_N       2
`define DCSW_CB_ENABLE_OP     3
`define DCSW_CB_FAULT_RESET   7
`define DCSW_CB_HALT          8
`define DCSW_CB_IO_FWD        0
`define DCSW_CB_IO3_RUN_AUTH  0
`define DCSW_CB_IO3_FWD_EDGE  1
`define DCSW_SRC_RESET        3'h0
`define DCSW_PROFILE_RESET    2'h0
`define DCSW_CMD_RESET        16'h0000
`endif

//--- dcsw_pkg.sv
package dcsw_pkg;
    typedef enum logic [2:0] {
        DCSW_SRC_TERMINAL         = 3'h0,
        DCSW_SRC_DISPLAY_TERMINAL = 3'h1,
        DCSW_SRC_MODBUS           = 3'h2,
        DCSW_SRC_CANOPEN          = 3'h3,
        DCSW_SRC_FIELDBUS         = 3'h4,
        DCSW_SRC_ONBOARD_ETHERNET = 3'h5
    } dcsw_src_e;

    typedef enum logic [1:0] {
        DCSW_PROF_STATE_MACHINE = 2'h0,
        DCSW_PROF_IO_2WIRE      = 2'h1,
        DCSW_PROF_IO_3WIRE      = 2'h2
    } dcsw_prof_e;

    typedef struct packed {
        logic ready_to_switch_on;
        logic switched_on;
        logic operation_enabled;
        logic fault;
        logic voltage_present;
        logic quick_stop;
        logic switch_on_disabled;
        logic warning;
        logic ref_reached;
        logic ref_out_of_limits;
        logic stop_key;
        logic reverse;
    } dcsw_status_s;

    typedef struct packed {
        logic       switch_on;
        logic       disable_voltage;
        logic       quick_stop;
        logic       enable_op;
        logic       fault_reset;
        logic       halt;
        logic       fwd_run;
        logic       run_auth;
        logic       fwd_start;
        logic [4:0] user_cmd;
    } dcsw_cmd_s;
endpackage : dcsw_pkg

//--- dcsw_cmd_master.sv
`timescale 1ns/10ps
module dcsw_cmd_master (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic [2:0]  src,
    input  wire logic        sm_profile,
    input  wire logic [15:0] word,
    output logic      [15:0] cmd [6]
);
    // Only the selected source carries the command; idle ones toggle every cycle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 6; i++) cmd[i] <= 16'h0000;
        end else begin
            for (int i = 0; i < 6; i++) begin
                if (i == int'(src)) begin
                    // Switch-on on bit 0, reserved bits kept clear in the state machine profile only
                    cmd[i] <= sm_profile ? (word & 16'hF98F) : word;
                end else begin
                    cmd[i] <= ~cmd[i];
                end
            end
        end
    end
endmodule : dcsw_cmd_master

//--- drive_control_status_words_tb.sv
`timescale 1ns/10ps
`include "dcsw_params.svh"
module drive_control_status_words_tb;
    import dcsw_pkg::*;
    logic               core_clk, rst, psel, penable, pwrite, pready, pslverr, er, sm;
    logic               canopen_present, fieldbus_present, power_section_only;
    logic [11:0]        paddr;
    logic [31:0]        pwdata, prdata, rd;
    logic [15:0]        src_words [6];
    logic [15:0]        word, drive_state_word;
    logic signed [15:0] ref_applied, pre_ramp_ref;
    logic [2:0]         src;
    dcsw_status_s       drive_status;
    dcsw_cmd_s          drive_cmd;
    int                 err_total, n_compared, fr_cnt, fs_cnt;

    dcsw_top u_dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .canopen_present(canopen_present),
        .fieldbus_present(fieldbus_present), .power_section_only(power_section_only),
        .terminal_cmd(src_words[0]), .display_terminal_cmd(src_words[1]),
        .modbus_cmd(src_words[2]), .canopen_cmd(src_words[3]),
        .fieldbus_cmd(src_words[4]), .ethernet_cmd(src_words[5]),
        .ref_applied(ref_applied), .drive_status(drive_status), .drive_cmd(drive_cmd),
        .drive_state_word(drive_state_word), .pre_ramp_ref(pre_ramp_ref));

    dcsw_cmd_master u_master (.core_clk(core_clk), .rst(rst), .src(src),
        .sm_profile(sm), .word(word), .cmd(src_words));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        if (drive_cmd.fault_reset === 1'b1) fr_cnt++;
        if (drive_cmd.fwd_start === 1'b1) fs_cnt++;
    end

    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            chk(32'hDEAD, 32'h0);
            wrap_up();
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
    endtask : wt

    task automatic done(input string s);
        $display("test %s done", s);
    endtask : done

    initial begin
        #100us;
        err_total++;
        $display("watchdog expired");
        wrap_up();
    end

    initial begin
        {psel, penable, pwrite, canopen_present, fieldbus_present} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        power_section_only = 1'b0;
        ref_applied = 16'h0000;
        drive_status = '0;
        word = 16'h0000;
        src = 3'h0;
        sm = 1'b1;
        err_total = 0;
        n_compared = 0;
        fr_cnt = 0;
        fs_cnt = 0;
        rst = 1'b1;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        apb(1'b0, `DCSW_OFS_CMD_SOURCE, 32'h0); chk(rd, 32'h0);
        apb(1'b0, `DCSW_OFS_PRE_RAMP_REF, 32'h0); chk(rd, 32'h0);
        done("reset");
        apb(1'b1, `DCSW_OFS_CMD_SOURCE, 32'h3);
        apb(1'b0, `DCSW_OFS_CMD_SOURCE, 32'h0); chk(rd, 32'h0);
        apb(1'b1, `DCSW_OFS_CMD_SOURCE, 32'h4);
        apb(1'b0, `DCSW_OFS_CMD_SOURCE, 32'h0); chk(rd, 32'h0);
        canopen_present <= 1'b1;
        fieldbus_present <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, `DCSW_OFS_CMD_SOURCE, i);
            apb(1'b0, `DCSW_OFS_CMD_SOURCE, 32'h0); chk(rd, i);
        end
        apb(1'b1, `DCSW_OFS_CMD_SOURCE, 32'h3);
        canopen_present <= 1'b0;
        wt(2);
        apb(1'b0, `DCSW_OFS_CMD_SOURCE, 32'h0); chk(rd, 32'h0);
        canopen_present <= 1'b1;
        apb(1'b1, `DCSW_OFS_CMD_SOURCE, 32'h2);
        src <= 3'h2;
        done("source");
        word <= 16'h8009;
        wt(4);
        chk({drive_cmd.switch_on, drive_cmd.disable_voltage, drive_cmd.quick_stop,
             drive_cmd.enable_op, drive_cmd.halt, drive_cmd.user_cmd}, 32'h3D0);
        word <= 16'h010E;
        wt(4);
        chk({drive_cmd.switch_on, drive_cmd.disable_voltage, drive_cmd.quick_stop,
             drive_cmd.enable_op, drive_cmd.halt, drive_cmd.user_cmd}, 32'h060);
        apb(1'b1, `DCSW_OFS_CMD_WORD, 32'h0000_0800);
        apb(1'b0, `DCSW_OFS_CMD_WORD, 32'h0); chk(rd, 32'h0800);
        apb(1'b0, `DCSW_OFS_EVENTS, 32'h0); chk(rd, 32'h090E);
        apb(1'b0, `DCSW_OFS_OUTPUTS, 32'h0); chk(rd, 32'h0501);
        fr_cnt = 0;
        word <= 16'h0086;
        wt(8);
        chk(fr_cnt, 1);
        done("state machine profile");
        apb(1'b1, `DCSW_OFS_PROFILE, 32'h1);
        sm <= 1'b0;
        word <= 16'h0001;
        wt(4);
        chk(drive_cmd.fwd_run, 1'b1);
        word <= 16'h0000;
        wt(4);
        chk(drive_cmd.fwd_run, 1'b0);
        apb(1'b1, `DCSW_OFS_PROFILE, 32'h2);
        fs_cnt = 0;
        word <= 16'h0002;
        wt(4);
        word <= 16'h0000;
        wt(3);
        word <= 16'h0001;
        wt(3);
        word <= 16'h0003;
        wt(8);
        chk(fs_cnt, 1);
        chk(drive_cmd.run_auth, 1'b1);
        apb(1'b1, `DCSW_OFS_PROFILE, 32'h3);
        apb(1'b0, `DCSW_OFS_PROFILE, 32'h0); chk(rd, 32'h2);
        done("io profile");
        apb(1'b1, `DCSW_OFS_PROFILE, 32'h0);
        sm <= 1'b1;
        drive_status <= 12'hB56;
        wt(3);
        chk(drive_state_word, 16'h4AAD);
        power_section_only <= 1'b1;
        wt(3);
        chk(drive_state_word, 16'h4ABD);
        apb(1'b0, `DCSW_OFS_STATE_WORD, 32'h0); chk(rd, 32'h4ABD);
        apb(1'b1, `DCSW_OFS_CMD_SOURCE, 32'h1);
        src <= 3'h1;
        drive_status <= 12'h4A9;
        wt(3);
        chk(drive_state_word, 16'h8452);
        done("state word");
        ref_applied <= 16'hE8FA;
        wt(3);
        apb(1'b0, `DCSW_OFS_PRE_RAMP_REF, 32'h0); chk(rd, 32'hFFFFE8FA);
        apb(1'b1, `DCSW_OFS_PRE_RAMP_REF, 32'h0);
        apb(1'b0, `DCSW_OFS_PRE_RAMP_REF, 32'h0); chk(rd, 32'hFFFFE8FA);
        apb(1'b0, 12'h020, 32'h0);
        chk(er, 1'b1);
        done("reference and decode");
        wrap_up();
    end
endmodule : drive_control_status_words_tb
